// File: design/tws_pkg.sv
// shared constants and types for the two-wire control slave
package tws_pkg;

  // ---------------------------------------------------------------
  // local register port map
  // ---------------------------------------------------------------
  localparam int unsigned LP_ADDR_W       = 9;
  localparam logic [8:0]  LP_CTRL         = 9'h000;
  localparam logic [8:0]  LP_MAIN_WADDR   = 9'h001;
  localparam logic [8:0]  LP_MAIN_RADDR   = 9'h002;
  localparam logic [8:0]  LP_FAST_WADDR   = 9'h003;
  localparam logic [8:0]  LP_FAST_RADDR   = 9'h004;
  localparam logic [8:0]  LP_STATUS       = 9'h005;
  localparam int unsigned LP_ARRAY_BIT    = 8;

  // control field positions
  localparam int unsigned CTRL_MAIN_ALT   = 0;
  localparam int unsigned CTRL_FAST_ALT   = 1;
  localparam int unsigned CTRL_MAIN_PDDIS = 2;
  localparam int unsigned CTRL_FAST_PDDIS = 3;
  localparam logic [3:0]  CTRL_RESET      = 4'h0;

  // slave address reset values
  localparam logic [7:0]  MAIN_WADDR_RST  = 8'h90;
  localparam logic [7:0]  MAIN_RADDR_RST  = 8'h91;
  localparam logic [7:0]  FAST_WADDR_RST  = 8'h92;
  localparam logic [7:0]  FAST_RADDR_RST  = 8'h93;

  // device register space
  localparam int unsigned REG_COUNT       = 256;
  localparam logic [7:0]  REG_TOP         = 8'hf0;
  localparam logic [6:0]  REG_PAGE_CTRL   = 7'h00;
  localparam logic [7:0]  REG_RESET       = 8'h00;

  // serial framing
  localparam int unsigned NUM_IFACE       = 2;
  localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;

  // pin 14 function code that selects the data function
  localparam logic [1:0]  PIN14_FUNC_DATA = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_RX,
    ST_TX,
    ST_MACK,
    ST_WAIT
  } tws_state_t;

endpackage : tws_pkg

// File: design/tws_line_sync.sv
// synchroniser and bus condition detector for one clock/data pair
`timescale 1ns/1ps
module tws_line_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      bus_start,
  output logic      bus_stop,
  output logic      sda_level
);
  import tws_pkg::*;

  logic [1:0] scl_meta_q, scl_meta_d;
  logic [1:0] sda_meta_q, sda_meta_d;
  logic       scl_old_q,  scl_old_d;
  logic       sda_old_q,  sda_old_d;

  // ---------------------------------------------------------------
  // two-stage capture, then one more stage for edge finding
  // ---------------------------------------------------------------
  always_comb begin
    scl_meta_d = {scl_meta_q[0], scl_in};
    sda_meta_d = {sda_meta_q[0], sda_in};
    scl_old_d  = scl_meta_q[1];
    sda_old_d  = sda_meta_q[1];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_meta_q <= 2'h3;
      sda_meta_q <= 2'h3;
      scl_old_q  <= 1'b1;
      sda_old_q  <= 1'b1;
    end else begin
      scl_meta_q <= scl_meta_d;
      sda_meta_q <= sda_meta_d;
      scl_old_q  <= scl_old_d;
      sda_old_q  <= sda_old_d;
    end
  end

  // ---------------------------------------------------------------
  // conditions, read from the settled second stage and the edge stage behind it
  // ---------------------------------------------------------------
  // data edges while the clock stays high mark start and stop
  assign scl_rise  = scl_meta_q[1] & ~scl_old_q;
  assign scl_fall  = ~scl_meta_q[1] & scl_old_q;
  assign bus_start = scl_meta_q[1] & scl_old_q
                     & sda_old_q & ~sda_meta_q[1];
  assign bus_stop  = scl_meta_q[1] & scl_old_q
                     & ~sda_old_q & sda_meta_q[1];
  assign sda_level = sda_meta_q[1];

endmodule : tws_line_sync

// File: design/tws_top.sv
// two-wire control slave: main and fast instances over one register space
//
// Behaviour
// - bytes are eight bits, most significant bit first
// - data changes while clock low, sampled on clock high
// - start is data falling with clock high, stop data rising
// - slave address, then register address byte, then data byte
// - when enabled, acknowledge own slave address by pulling data low
// - single write: start, address, register, data, stop, all acknowledged
// - master ack on read byte increments pointer and sends next
// - nonexistent register locations read back as zero
// - several data bytes in a write store at incrementing pointer
// - alternate mode: bytes alternate register address and data
// - start inside a message restarts the address phase, stop returns the engine to idle
// - fast instance has own addresses, default 0x92 and 0x93
// - fast instance active only when pin 14 selects data function or config load is set
// - fast instance enabled masks pin 15 select and mode controls
// - fast address match raises access event, optional wakeup
// - config load forces fast instance on, supplied from core rail
// - interfaces keep running in power-down unless disabled
// - main instance addresses default 0x90 and 0x91
// - register address msb selects the page directly
// - follow master clock, never stretch it
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
module tws_top (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // local register port
  input  wire logic [tws_pkg::LP_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [7:0]                    reg_rdata,
  // main two-wire bus
  input  wire logic                          main_scl_in,
  input  wire logic                          main_sda_in,
  output logic                               main_sda_out,
  output logic                               main_sda_oe,
  // fast two-wire bus
  input  wire logic                          fast_scl_in,
  input  wire logic                          fast_sda_in,
  output logic                               fast_sda_out,
  output logic                               fast_sda_oe,
  // device mode and pin controls
  input  wire logic                          power_down,
  input  wire logic [1:0]                    pin14_function_select,
  input  wire logic                          pin14_wakeup_option,
  input  wire logic [1:0]                    pin15_function_select,
  input  wire logic [1:0]                    pin15_mode_control,
  input  wire logic                          pin15_supply_select,
  input  wire logic                          config_load_select_pin,
  output logic      [1:0]                    pin15_function_eff,
  output logic      [1:0]                    pin15_mode_eff,
  output logic                               fast_core_supply,
  output logic                               access_interrupt_event,
  output logic                               access_wakeup_event
);
  import tws_pkg::*;

  // ---------------------------------------------------------------
  // reset release and strap synchroniser
  // ---------------------------------------------------------------
  logic       rst_s1_q, rst_n_s;
  logic [1:0] cfg_sync_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_s  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_s  <= rst_s1_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) cfg_sync_q <= 2'h0;
    else          cfg_sync_q <= {cfg_sync_q[0], config_load_select_pin};
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [3:0] ctrl_q, ctrl_d;
  logic [7:0] waddr_q [NUM_IFACE];
  logic [7:0] raddr_q [NUM_IFACE];
  logic [7:0] waddr_d [NUM_IFACE];
  logic [7:0] raddr_d [NUM_IFACE];
  logic [7:0] rdata_q, rdata_d;
  logic [NUM_IFACE-1:0] en_q, en_d, busy;

  // per-engine handshake towards the register space
  logic [NUM_IFACE-1:0] wreq, grant;
  logic [7:0]           wr_a  [NUM_IFACE];
  logic [7:0]           wr_v  [NUM_IFACE];
  logic [7:0]           fetch [NUM_IFACE];
  logic [NUM_IFACE-1:0] hit;

  logic [7:0] mem_q [REG_COUNT];

  always_comb begin
    ctrl_d     = ctrl_q;
    waddr_d[0] = waddr_q[0];
    raddr_d[0] = raddr_q[0];
    waddr_d[1] = waddr_q[1];
    raddr_d[1] = raddr_q[1];
    rdata_d    = 8'h00;
    if (reg_wr && !reg_addr[LP_ARRAY_BIT]) begin
      case (reg_addr)
        LP_CTRL:       ctrl_d     = reg_wdata[3:0];
        LP_MAIN_WADDR: waddr_d[0] = reg_wdata;
        LP_MAIN_RADDR: raddr_d[0] = reg_wdata;
        LP_FAST_WADDR: waddr_d[1] = reg_wdata;
        LP_FAST_RADDR: raddr_d[1] = reg_wdata;
        default:       ctrl_d     = ctrl_q;
      endcase
    end
    if (reg_rd) begin
      if (reg_addr[LP_ARRAY_BIT]) begin
        rdata_d = mem_q[reg_addr[7:0]];
      end else begin
        case (reg_addr)
          LP_CTRL:       rdata_d = {4'h0, ctrl_q};
          LP_MAIN_WADDR: rdata_d = waddr_q[0];
          LP_MAIN_RADDR: rdata_d = raddr_q[0];
          LP_FAST_WADDR: rdata_d = waddr_q[1];
          LP_FAST_RADDR: rdata_d = raddr_q[1];
          LP_STATUS:     rdata_d = {4'h0, busy, en_q};
          default:       rdata_d = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ctrl_q     <= CTRL_RESET;
      waddr_q[0] <= MAIN_WADDR_RST;
      raddr_q[0] <= MAIN_RADDR_RST;
      waddr_q[1] <= FAST_WADDR_RST;
      raddr_q[1] <= FAST_RADDR_RST;
      rdata_q    <= 8'h00;
    end else begin
      ctrl_q     <= ctrl_d;
      waddr_q[0] <= waddr_d[0];
      raddr_q[0] <= raddr_d[0];
      waddr_q[1] <= waddr_d[1];
      raddr_q[1] <= raddr_d[1];
      rdata_q    <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // enables, pin 15 masking, events
  // ---------------------------------------------------------------
  logic       fast_sel;
  logic [1:0] p15f_q, p15f_d, p15m_q, p15m_d;
  logic       core_q, core_d, evt_q, evt_d, wake_q, wake_d;

  // config load forces the fast instance on regardless of pin 14
  assign fast_sel = (pin14_function_select == PIN14_FUNC_DATA)
                    | cfg_sync_q[1];

  always_comb begin
    en_d[0] = ~(power_down & ctrl_q[CTRL_MAIN_PDDIS]);
    en_d[1] = fast_sel
              & ~(power_down & ctrl_q[CTRL_FAST_PDDIS]);
    p15f_d  = fast_sel ? 2'h0 : pin15_function_select;
    p15m_d  = fast_sel ? 2'h0 : pin15_mode_control;
    core_d  = cfg_sync_q[1] | (fast_sel & pin15_supply_select);
    evt_d   = hit[1];
    wake_d  = hit[1] & pin14_wakeup_option;
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      en_q   <= '0;
      p15f_q <= 2'h0;
      p15m_q <= 2'h0;
      core_q <= 1'b0;
      evt_q  <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      en_q   <= en_d;
      p15f_q <= p15f_d;
      p15m_q <= p15m_d;
      core_q <= core_d;
      evt_q  <= evt_d;
      wake_q <= wake_d;
    end
  end

  // ---------------------------------------------------------------
  // register space
  // ---------------------------------------------------------------
  // main wins a same-cycle clash; the fast write waits one cycle
  assign grant[0] = wreq[0];
  assign grant[1] = wreq[1] & ~wreq[0];

  function automatic logic reg_exists(input logic [7:0] a);
    reg_exists = (a[6:0] != REG_PAGE_CTRL) && (a < REG_TOP);
  endfunction : reg_exists

  // a local port write lands last and so overrides the engines
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      for (int i = 0; i < REG_COUNT; i++) mem_q[i] <= REG_RESET;
    end else begin
      for (int e = 0; e < NUM_IFACE; e++) begin
        if (grant[e] && reg_exists(wr_a[e])) mem_q[wr_a[e]] <= wr_v[e];
      end
      if (reg_wr && reg_addr[LP_ARRAY_BIT] && reg_exists(reg_addr[7:0]))
        mem_q[reg_addr[7:0]] <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // protocol engines, one per bus
  // ---------------------------------------------------------------
  logic [NUM_IFACE-1:0] scl_i, sda_i, oe;

  assign scl_i = {fast_scl_in, main_scl_in};
  assign sda_i = {fast_sda_in, main_sda_in};

  for (genvar g = 0; g < NUM_IFACE; g++) begin : g_eng
    logic       rise, fall, start, stop, sda;
    logic       alt;
    tws_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d, ptr_q, ptr_d, wa_q, wa_d, wv_q, wv_d;
    logic       role_q, role_d, rw_q, rw_d, oe_q, oe_d;
    logic       wreq_q, wreq_d, hit_q, hit_d;

    tws_line_sync u_sync (
      .clk       (clk),
      .rst_n     (rst_n_s),
      .scl_in    (scl_i[g]),
      .sda_in    (sda_i[g]),
      .scl_rise  (rise),
      .scl_fall  (fall),
      .bus_start (start),
      .bus_stop  (stop),
      .sda_level (sda)
    );

    assign alt      = ctrl_q[g];
    assign fetch[g] = reg_exists(ptr_q) ? mem_q[ptr_q] : 8'h00;
    assign wreq[g]  = wreq_q;
    assign wr_a[g]  = wa_q;
    assign wr_v[g]  = wv_q;
    assign hit[g]   = hit_q;
    assign oe[g]    = oe_q;
    assign busy[g]  = (state_q != ST_IDLE);

    // only the data line is driven; the clock is never held
    always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      sh_d    = sh_q;
      ptr_d   = ptr_q;
      role_d  = role_q;
      rw_d    = rw_q;
      oe_d    = oe_q;
      wa_d    = wa_q;
      wv_d    = wv_q;
      wreq_d  = wreq_q & ~grant[g];
      hit_d   = 1'b0;
      if (!en_q[g]) begin
        state_d = ST_IDLE;
        oe_d    = 1'b0;
      end else if (start) begin
        state_d = ST_ADDR;
        cnt_d   = 4'h0;
        role_d  = 1'b0;
        oe_d    = 1'b0;
      end else if (stop) begin
        state_d = ST_IDLE;
        oe_d    = 1'b0;
      end else begin
        case (state_q)
          ST_ADDR, ST_RX: begin
            if (rise) begin
              sh_d  = {sh_q[6:0], sda};
              cnt_d = cnt_q + 4'h1;
            end else if (fall && cnt_q == BITS_PER_BYTE) begin
              oe_d    = 1'b1;
              state_d = ST_ACK;
              if (state_q == ST_ADDR) begin
                hit_d = 1'b1;
                if (sh_q == waddr_q[g]) begin
                  rw_d = 1'b0;
                end else if (sh_q == raddr_q[g]) begin
                  rw_d = 1'b1;
                end else begin
                  oe_d    = 1'b0;
                  hit_d   = 1'b0;
                  state_d = ST_WAIT;
                end
              end else if (!role_q) begin
                ptr_d  = sh_q;
                role_d = 1'b1;
              end else begin
                wreq_d = 1'b1;
                wa_d   = ptr_q;
                wv_d   = sh_q;
                if (alt) role_d = 1'b0;
                else     ptr_d  = ptr_q + 8'h01;
              end
            end
          end
          ST_ACK: begin
            if (fall) begin
              cnt_d = 4'h0;
              if (rw_q) begin
                sh_d    = fetch[g];
                oe_d    = ~fetch[g][7];
                state_d = ST_TX;
              end else begin
                oe_d    = 1'b0;
                state_d = ST_RX;
              end
            end
          end
          ST_TX: begin
            if (rise) begin
              cnt_d = cnt_q + 4'h1;
            end else if (fall) begin
              if (cnt_q == BITS_PER_BYTE) begin
                oe_d    = 1'b0;
                state_d = ST_MACK;
              end else begin
                sh_d = {sh_q[6:0], 1'b0};
                oe_d = ~sh_q[6];
              end
            end
          end
          ST_MACK: begin
            if (rise) begin
              role_d = ~sda;
              if (!sda) ptr_d = ptr_q + 8'h01;
            end else if (fall) begin
              if (role_q) begin
                cnt_d   = 4'h0;
                sh_d    = fetch[g];
                oe_d    = ~fetch[g][7];
                state_d = ST_TX;
              end else begin
                oe_d    = 1'b0;
                state_d = ST_WAIT;
              end
            end
          end
          ST_IDLE, ST_WAIT: oe_d = 1'b0;
          default: begin
            state_d = ST_IDLE;
            oe_d    = 1'b0;
          end
        endcase
      end
    end

    always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
        state_q <= ST_IDLE;
        cnt_q   <= 4'h0;
        sh_q    <= 8'h00;
        ptr_q   <= 8'h00;
        role_q  <= 1'b0;
        rw_q    <= 1'b0;
        oe_q    <= 1'b0;
        wa_q    <= 8'h00;
        wv_q    <= 8'h00;
        wreq_q  <= 1'b0;
        hit_q   <= 1'b0;
      end else begin
        state_q <= state_d;
        cnt_q   <= cnt_d;
        sh_q    <= sh_d;
        ptr_q   <= ptr_d;
        role_q  <= role_d;
        rw_q    <= rw_d;
        oe_q    <= oe_d;
        wa_q    <= wa_d;
        wv_q    <= wv_d;
        wreq_q  <= wreq_d;
        hit_q   <= hit_d;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs, each from a flip-flop; open drain drives only low
  // ---------------------------------------------------------------
  logic drive_low_q;

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) drive_low_q <= 1'b0;
    else          drive_low_q <= 1'b0;
  end

  assign reg_rdata              = rdata_q;
  assign main_sda_out           = drive_low_q;
  assign fast_sda_out           = drive_low_q;
  assign main_sda_oe            = oe[0];
  assign fast_sda_oe            = oe[1];
  assign pin15_function_eff     = p15f_q;
  assign pin15_mode_eff         = p15m_q;
  assign fast_core_supply       = core_q;
  assign access_interrupt_event = evt_q;
  assign access_wakeup_event    = wake_q;

endmodule : tws_top

// File: test/tws_top_asserts.sv
// concurrent checks on the two-wire control slave top ports
`timescale 1ns/1ps
module tws_top_asserts (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [8:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       main_scl_in,
  input wire logic       main_sda_out,
  input wire logic       fast_sda_out,
  input wire logic       main_sda_oe,
  input wire logic       fast_sda_oe,
  input wire logic [1:0] pin14_function_select,
  input wire logic [1:0] pin15_function_select,
  input wire logic       pin15_supply_select,
  input wire logic       config_load_select_pin,
  input wire logic [1:0] pin15_function_eff,
  input wire logic [1:0] pin15_mode_eff,
  input wire logic       fast_core_supply,
  input wire logic       access_interrupt_event,
  input wire logic       access_wakeup_event
);
  import tws_pkg::*;
  logic [2:0] rdy_q, rdy_d;
  wire        rdy  = rdy_q[2];
  wire        fsel = pin14_function_select == PIN14_FUNC_DATA;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // settle counter: the design holds its own reset two edges longer
  always_comb begin
    rdy_d = rdy ? rdy_q : rdy_q + 3'h1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_q <= 3'h0;
    end else begin
      rdy_q <= rdy_d;
    end
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  // open drain: only the enable may carry the bit
  drive_low_a: assert property (!main_sda_out && !fast_sda_out)
    else $error("data output not low");
  oe_clock_low_a: assert property ($changed(main_sda_oe) |-> !$past(main_scl_in))
    else $error("main data enable moved with clock high");
  fast_off_a: assert property ((!fsel && !config_load_select_pin) [*4]
    |-> !fast_sda_oe && !access_interrupt_event)
    else $error("fast bus active while deselected");
  mask_pin15_a: assert property (fsel
    |=> pin15_function_eff == 2'h0 && pin15_mode_eff == 2'h0)
    else $error("pin15 controls not masked");
  pass_pin15_a: assert property ((rdy && !fsel && !config_load_select_pin) [*3]
    |=> pin15_function_eff == $past(pin15_function_select))
    else $error("pin15 select not passed through");
  core_rail_a: assert property ((rdy && !config_load_select_pin) [*3]
    |=> fast_core_supply == $past(fsel && pin15_supply_select))
    else $error("core supply select wrong");
  irq_pulse_a: assert property (access_interrupt_event
    |=> !access_interrupt_event ##1 !access_interrupt_event)
    else $error("access event longer than one cycle");
  wake_gate_a: assert property (access_wakeup_event |-> access_interrupt_event)
    else $error("wakeup without access event");
  zero_reg_a: assert property (reg_rd && reg_addr[8]
    && (reg_addr[6:0] == 7'h00 || reg_addr[7:0] >= REG_TOP)
    |=> reg_rdata == REG_RESET)
    else $error("missing register read nonzero");
  main_ack_c: cover property ($rose(main_sda_oe));
  fast_ack_c: cover property ($rose(fast_sda_oe));
  wake_c: cover property (access_wakeup_event);
endmodule : tws_top_asserts

bind tws_top tws_top_asserts tws_top_asserts_inst (.clk, .rst_n, .reg_addr,
  .reg_rd, .reg_rdata, .main_scl_in, .main_sda_out, .main_sda_oe, .fast_sda_oe,
  .pin14_function_select, .pin15_function_select, .pin15_supply_select,
  .config_load_select_pin, .pin15_function_eff, .pin15_mode_eff, .fast_sda_out,
  .fast_core_supply, .access_interrupt_event, .access_wakeup_event);

// File: test/tws_host_model.sv
// behavioural two-wire bus master standing in for a host processor
`timescale 1ns/1ps
module tws_host_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // idle bus: both lines released, clock stands high outside frames
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // one bit slot of 160 ns: data moves with clock low, read mid high
  task automatic bit_x(input logic b, output logic seen);
    sda_low = ~b;
    #80 scl = 1'b1;
    #40 seen = sda;
    #40 scl = 1'b0;
  endtask : bit_x

  // nine slots msb first, the last one being the acknowledge slot
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      bit_x(tx[i], rx[i]);
    end
  endtask : xfer

  // start or repeated start; waits out the slave's data hold first
  task automatic start();
    sda_low = 1'b0;
    #100 scl = 1'b1;
    #80 sda_low = 1'b1;
    #80 scl = 1'b0;
  endtask : start

  task automatic stop();
    sda_low = 1'b1;
    #100 scl = 1'b1;
    #80 sda_low = 1'b0;
    #80;
  endtask : stop
endmodule : tws_host_model

// File: test/tws_top_tb_top.sv
// self-checking bench for the two-wire control slave
`timescale 1ns/1ps
module tws_top_tb_top;
  import tws_pkg::*;
  typedef struct {logic [8:0] a; logic w; logic [7:0] d, e;} tws_row_t;
  logic       clk, rst_n, reg_wr, reg_rd, power_down, main_scl_in, m_low;
  logic       main_sda_out, main_sda_oe, fast_scl_in, fast_sda_out, f_low;
  logic       fast_sda_oe, pin14_wakeup_option, pin15_supply_select;
  logic       config_load_select_pin, fast_core_supply;
  logic       access_interrupt_event, access_wakeup_event;
  logic [1:0] pin14_function_select, pin15_function_select;
  logic [1:0] pin15_mode_control, pin15_function_eff, pin15_mode_eff;
  logic [8:0] reg_addr, r;
  logic [7:0] reg_wdata, reg_rdata;
  int         n_errors, checks, cyc, n_irq, n_wk;
  wire        main_sda_in = ~(m_low | main_sda_oe);
  wire        fast_sda_in = ~(f_low | fast_sda_oe);
  tws_row_t   rows [9] = '{'{9'h001, 0, 8'h00, 8'h90}, '{9'h002, 0, 0, 8'h91},
    '{9'h003, 0, 0, 8'h92}, '{9'h004, 0, 0, 8'h93}, '{9'h006, 1, 8'h55, 0},
    '{9'h100, 1, 8'h77, 0}, '{9'h180, 1, 8'h77, 0}, '{9'h1f0, 1, 8'h12, 0},
    '{9'h1ef, 1, 8'h3c, 8'h3c}};

  tws_top tws_top_inst (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .main_scl_in, .main_sda_in, .main_sda_out, .main_sda_oe,
    .fast_scl_in, .fast_sda_in, .fast_sda_out, .fast_sda_oe, .power_down,
    .pin14_function_select, .pin14_wakeup_option, .pin15_function_select,
    .pin15_mode_control, .pin15_supply_select, .config_load_select_pin,
    .pin15_function_eff, .pin15_mode_eff, .fast_core_supply,
    .access_interrupt_event, .access_wakeup_event);
  tws_host_model hm_main (.scl(main_scl_in), .sda_low(m_low), .sda(main_sda_in));
  tws_host_model hm_fast (.scl(fast_scl_in), .sda_low(f_low), .sda(fast_sda_in));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // cycle ceiling well above the ~2800 cycles the run needs; event counts
  always @(posedge clk) begin
    cyc++;
    n_irq += int'(access_interrupt_event === 1'b1);
    n_wk += int'(access_wakeup_event === 1'b1);
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [8:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 chk("reg_rdata", {1'b0, reg_rdata}, {1'b0, e});
  endtask : rd

  task automatic mb(input logic [7:0] b, input logic a);
    hm_main.xfer({b, 1'b1}, r);
    chk("main ack", {8'h00, r[0]}, {8'h00, ~a});
  endtask : mb

  // whole write frame on either bus; a tells whether acks are due
  task automatic frame(input logic f, input logic [7:0] q[$], input logic a);
    if (f) hm_fast.start();
    else hm_main.start();
    foreach (q[i]) begin
      if (f) hm_fast.xfer({q[i], 1'b1}, r);
      else hm_main.xfer({q[i], 1'b1}, r);
      chk("slave ack", {8'h00, r[0]}, {8'h00, ~a});
    end
    if (f) hm_fast.stop();
    else hm_main.stop();
  endtask : frame

  // pointer write, repeated start, two bytes: master ack then nack
  task automatic mread(input logic [7:0] p, e1, e2);
    hm_main.start();
    mb(8'h90, 1'b1);
    mb(p, 1'b1);
    hm_main.start();
    mb(8'h91, 1'b1);
    hm_main.xfer(9'h1fe, r);
    chk("read byte", {1'b0, r[8:1]}, {1'b0, e1});
    hm_main.xfer(9'h1ff, r);
    chk("read byte", {1'b0, r[8:1]}, {1'b0, e2});
    hm_main.stop();
  endtask : mread

  task automatic results();
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_n, reg_wr, reg_rd, power_down, config_load_select_pin} = '0;
    {reg_addr, reg_wdata, pin14_function_select} = '0;
    {pin15_function_select, pin15_mode_control} = 4'h9;
    {pin14_wakeup_option, pin15_supply_select} = 2'h3;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk("pin15 func", {7'h0, pin15_function_eff}, 9'h002);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    frame(1'b0, '{8'h90, 8'h10, 8'ha5}, 1'b1);
    rd(9'h110, 8'ha5);
    power_down <= 1'b1;
    frame(1'b0, '{8'h90, 8'h20, 8'h11, 8'h22}, 1'b1);
    rd(9'h121, 8'h22);
    wr(9'h000, 8'h04);
    frame(1'b0, '{8'h90}, 1'b0);
    wr(9'h000, 8'h01);
    power_down <= 1'b0;
    mread(8'h20, 8'h11, 8'h22);
    mread(8'hef, 8'h3c, 8'h00);
    frame(1'b0, '{8'h90, 8'h30, 8'h44, 8'h40, 8'h55}, 1'b1);
    rd(9'h130, 8'h44);
    rd(9'h140, 8'h55);
    rd(9'h131, 8'h00);
    wr(9'h000, 8'h00);
    frame(1'b0, '{8'h94, 8'h50, 8'h66}, 1'b0);
    hm_main.start();
    mb(8'h90, 1'b1);
    mb(8'h50, 1'b1);
    repeat (4) hm_main.bit_x(1'b0, r[0]);
    hm_main.stop();
    rd(9'h150, 8'h00);
    rd(LP_STATUS, 8'h01);
    frame(1'b1, '{8'h92, 8'h61, 8'h99}, 1'b0);
    pin14_function_select <= PIN14_FUNC_DATA;
    repeat (4) @(posedge clk);
    chk("pin15 mode", {7'h0, pin15_mode_eff}, 9'h000);
    chk("access events", 9'(n_irq), 9'h000);
    frame(1'b1, '{8'h92, 8'h61, 8'h99}, 1'b1);
    rd(9'h161, 8'h99);
    chk("access events", 9'(n_irq), 9'h001);
    chk("wakeup events", 9'(n_wk), 9'h001);
    pin14_function_select <= 2'h0;
    config_load_select_pin <= 1'b1;
    repeat (5) @(posedge clk);
    chk("core supply", {8'h00, fast_core_supply}, 9'h001);
    results();
  end
endmodule : tws_top_tb_top
